//--- bench/exd_fw_model.sv
// Handler firmware model: loads the return address, then returns
`timescale 1ns/100ps
module exd_fw_model
	import exd_pkg::*;
(
	// Clock, reset and request
	input  wire logic            clk_i,
	input  wire logic            nrst_i,
	input  wire logic            go_i,
	input  wire logic [PC_W-1:0] addr_i,
	// Toward the unit
	output logic                 we_o,
	output logic [PC_W-1:0]      wd_o,
	output logic                 iv_o,
	output logic [31:0]          ins_o
);
	logic [1:0] seq_reg;
	// Write, one idle cycle, then the return; idle lines toggle
	// Only the return address is written; the handler base is never touched by this model
	always @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			{seq_reg, we_o, iv_o, wd_o, ins_o} <= '0;
		end else begin
			seq_reg <= {seq_reg[0], go_i};
			we_o <= go_i;
			wd_o <= go_i ? addr_i : ~wd_o;
			iv_o <= seq_reg[1];
			ins_o <= seq_reg[1] ? {OPC_RETURN, 5'h1f, 5'h1f, 2'b10, 14'h0} : ~ins_o;
		end
	end
endmodule : exd_fw_model

//--- bench/exd_top_assertions.sv
// Checker for the exception dispatch and return unit
`timescale 1ns/100ps
module exd_top_chk
	import exd_pkg::*;
(
	// Clock and reset
	input  wire logic             core_clk_i,
	input  wire logic             nrst_i,
	// Drain status
	input  wire logic             regfile_writers_done_i,
	input  wire logic             no_fault_possible_i,
	input  wire logic             dcache_fills_done_i,
	// Unit outputs
	input  wire logic             drain_req_o,
	input  wire logic             redirect_o,
	input  wire logic [PC_W-1:0]  virtual_program_counter_o,
	input  wire logic             privileged_handler_mode_o,
	input  wire logic [PC_W-1:0]  exception_return_address_o,
	input  wire logic [PC_W-1:0]  handler_base_address_o,
	input  wire logic             stack_push_o,
	input  wire logic [PC_W-1:0]  stack_push_data_o,
	input  wire logic [OFS_W-1:0] entry_offset_o
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!nrst_i);
	// Short names for the drained condition, a return and a dispatch
	wire dr = regfile_writers_done_i & no_fault_possible_i & dcache_fills_done_i;
	wire rt = redirect_o & stack_push_o;
	wire dp = redirect_o & ~stack_push_o;
	wire [PC_W-1:0] pd = stack_push_data_o;
	// Return target, mode and pushed value
	ret_target_a: assert property (rt |-> virtual_program_counter_o == (pd & ~ALIGN_MASK))
		else $error("return target wrong");
	ret_mode_a: assert property (rt |-> privileged_handler_mode_o == pd[0])
		else $error("mode after return wrong");
	push_value_a: assert property (stack_push_o |-> pd == $past(exception_return_address_o))
		else $error("pushed value wrong");
	// Entry address, drain and reset entry
	entry_pc_a: assert property (dp |-> virtual_program_counter_o ==
		{handler_base_address_o[PC_W-1:OFS_W], entry_offset_o})
		else $error("entry address wrong");
	drain_hold_a: assert property (drain_req_o && !dr |=> drain_req_o)
		else $error("drain ended early");
	drain_order_a: assert property (drain_req_o && dr |=> !drain_req_o ##1 !redirect_o ##1 dp)
		else $error("dispatch order wrong");
	reset_entry_a: assert property ($rose(nrst_i) |=> dp && entry_offset_o == OFS_RESET)
		else $error("reset entry wrong");
	offset_stable_a: assert property (drain_req_o ##1 drain_req_o |-> $stable(entry_offset_o))
		else $error("offset moved in drain");
	// Main scenarios
	cover property (rt);
	cover property (dp && entry_offset_o >= OFS_CALLP);
	cover property (drain_req_o && !dr);
endmodule : exd_top_chk

bind exd_top exd_top_chk exd_top_chk_i (.core_clk_i, .nrst_i, .regfile_writers_done_i,
	.no_fault_possible_i, .dcache_fills_done_i, .drain_req_o, .redirect_o,
	.virtual_program_counter_o, .privileged_handler_mode_o, .exception_return_address_o,
	.handler_base_address_o, .stack_push_o, .stack_push_data_o, .entry_offset_o);

//--- bench/exd_top_bench.sv
// Self-checking bench for the exception dispatch and return unit
`timescale 1ns/100ps
module exd_top_bench;
	import exd_pkg::*;
	logic              clk, nrst, ce, tv, km, bwe, go, fv, fwe, dq, rd, hm, sp;
	logic [13:0]       c, eo;
	logic [2:0]        dr;
	logic [31:0]       ti, fw;
	logic [PC_W-1:0]   pc, fa, fwd, npc, ra, ba, spd;
	int                miscompares, comparisons;
	localparam logic [PC_W-1:0] B = 34'h2_a5a5_5a5a;
	// Unit under test
	exd_top exd_top_i (.core_clk_i(clk), .nrst_i(nrst), .clk_en_i(ce),
		.instr_valid_i(tv | fv), .instr_i(fv ? fw : ti), .instr_pc_i(pc), .kernel_mode_i(km),
		.mcheck_i(c[0]), .atrap_i(c[1]), .intr_i(c[2]), .imiss_i(c[3]), .iacv_i(c[4]),
		.rsvd_opc_i(c[5]), .fp_op_i(c[6]), .fp_enable_i(c[7]), .fp_bad_round_i(c[8]),
		.fp_bad_type_i(c[9]), .bad_vaddr_i(c[10]), .dmiss_i(c[11]), .misalign_i(c[12]),
		.other_fault_i(c[13]), .regfile_writers_done_i(dr[0]), .no_fault_possible_i(dr[1]),
		.dcache_fills_done_i(dr[2]), .ret_addr_we_i(fwe), .ret_addr_wdata_i(fwd),
		.base_we_i(bwe), .base_wdata_i(B), .drain_req_o(dq), .redirect_o(rd),
		.virtual_program_counter_o(npc), .privileged_handler_mode_o(hm),
		.exception_return_address_o(ra), .handler_base_address_o(ba), .stack_push_o(sp),
		.stack_push_data_o(spd), .entry_offset_o(eo));
	// Firmware at the far side
	exd_fw_model exd_fw_model_i (.clk_i(clk), .nrst_i(nrst), .go_i(go), .addr_i(fa),
		.we_o(fwe), .wd_o(fwd), .iv_o(fv), .ins_o(fw));
	// Clock
	always #12.5 clk = ~clk;
	task automatic chk(input logic [PC_W-1:0] a, input logic [PC_W-1:0] e);
		comparisons++;
		if (a !== e) begin
			miscompares++;
			$display("[ERR] %0t got %h exp %h", $time, a, e);
		end
	endtask : chk
	// One exception: causes, {kernel, call, code}, expected offset
	task automatic ex(input logic [13:0] v, input logic [9:0] kc, input logic [13:0] o);
		logic [PC_W-1:0] er;
		er = o[13] ? pc + 34'h4 : pc;
		@(posedge clk);
		c <= v;
		km <= kc[9];
		tv <= kc[8];
		ti <= {24'h0, kc[7:0]};
		dr <= 3'b011;
		@(posedge clk);
		c <= '0;
		tv <= 1'b0;
		@(negedge clk);
		chk(34'(dq), 34'h1);
		@(negedge clk);
		chk(34'(dq), 34'h1);
		@(posedge clk);
		dr <= 3'b111;
		for (int i = 0; i < 8 && rd !== 1'b1; i++) @(negedge clk);
		chk(34'(rd), 34'h1);
		chk(34'(eo), 34'(o));
		chk(npc, {B[33:14], o});
		chk(ra, er);
		$display("Exception test %h done", o);
	endtask : ex
	// One return through the firmware model
	task automatic rt(input logic [PC_W-1:0] a);
		@(posedge clk);
		go <= 1'b1;
		fa <= a;
		@(posedge clk);
		go <= 1'b0;
		for (int i = 0; i < 8 && sp !== 1'b1; i++) @(negedge clk);
		chk(34'(sp), 34'h1);
		chk(npc, a & ~34'h3);
		chk(34'(hm), 34'(a[0]));
		chk(spd, a);
		$display("Return test %h done", a);
	endtask : rt
	task give_verdict;
		$display("Comparisons %0d, mismatches %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : give_verdict
	// Watchdog
	initial begin
		#50us;
		miscompares++;
		give_verdict();
	end
	// Main sequence
	initial begin
		{clk, nrst, tv, km, bwe, go, c, ti, fa} = '0;
		dr = 3'b111;
		ce = 1'b1;
		pc = 34'h1_2345_6788;
		repeat (16) @(posedge clk);
		nrst <= 1'b1;
		repeat (2) @(negedge clk);
		chk(34'(rd), 34'h1);
		chk(npc, 34'h0);
		@(posedge clk);
		bwe <= 1'b1;
		@(posedge clk);
		bwe <= 1'b0;
		@(negedge clk);
		chk(ba, B);
		$display("Reset and base test done");
		// Clock enable low: a pending cause must not be taken
		@(posedge clk);
		ce <= 1'b0;
		c <= 14'h0001;
		repeat (2) @(negedge clk);
		chk(34'(dq), 34'h0);
		@(posedge clk);
		c <= '0;
		ce <= 1'b1;
		@(negedge clk);
		chk(34'(rd), 34'h0);
		chk(npc, 34'h0);
		$display("Clock enable freeze test done");
		ex(14'h0003, 10'h000, 14'h0020);
		ex(14'h0006, 10'h000, 14'h0060);
		ex(14'h2004, 10'h000, 14'h00e0);
		ex(14'h2008, 10'h000, 14'h01e0);
		ex(14'h1400, 10'h000, 14'h11e0);
		ex(14'h1800, 10'h000, 14'h09e0);
		ex(14'h1000, 10'h000, 14'h11e0);
		ex(14'h0018, 10'h000, 14'h03e0);
		ex(14'h0010, 10'h305, 14'h07e0);
		ex(14'h0020, 10'h33f, 14'h2fc0);
		ex(14'h0000, 10'h305, 14'h2140);
		ex(14'h0000, 10'h180, 14'h3000);
		ex(14'h0000, 10'h1bf, 14'h3fc0);
		ex(14'h0000, 10'h340, 14'h13e0);
		ex(14'h0000, 10'h3c0, 14'h13e0);
		ex(14'h0000, 10'h105, 14'h13e0);
		ex(14'h0060, 10'h000, 14'h13e0);
		ex(14'h0040, 10'h000, 14'h17e0);
		ex(14'h01c0, 10'h000, 14'h17e0);
		ex(14'h02c0, 10'h000, 14'h17e0);
		rt(34'h1_0000_1237);
		rt(34'h0_0000_2002);
		ex(14'h0800, 10'h000, 14'h08e0);
		give_verdict();
	end
endmodule : exd_top_bench

//--- verilog/exd_dstream_class.sv
// Data-stream memory error classifier
`timescale 1ns/100ps
module exd_dstream_class
	import exd_pkg::*;
(
	// Error classes
	input  wire logic             bad_vaddr_i,
	input  wire logic             dmiss_i,
	input  wire logic             misalign_i,
	input  wire logic             other_fault_i,
	input  wire logic             handler_mode_i,
	// Result
	output logic                  derr_o,
	output logic [OFS_W-1:0]      derr_ofs_o
);
	// Class priority inside the data-stream group
	always_comb begin
		derr_o = bad_vaddr_i | dmiss_i | misalign_i | other_fault_i;
		if (bad_vaddr_i) begin
			derr_ofs_o = misalign_i ? OFS_UNALGN : OFS_DFAULT;
		end else if (dmiss_i) begin
			derr_ofs_o = handler_mode_i ? OFS_DMISSP : OFS_DMISSN;
		end else if (misalign_i) begin
			derr_ofs_o = OFS_UNALGN;
		end else begin
			derr_ofs_o = OFS_DFAULT;
		end
	end
endmodule : exd_dstream_class

//--- verilog/exd_pkg.sv
// Constants and types shared by the exception dispatch and return block
// Notes on behaviour
// - Return loads program counter from return address with low two bits cleared.
// - After return, handler mode equals bit 0 of the return address.
// - Return instruction is recognised by opcode value 30 in the top bits.
// - Return pushes the return address onto the return prediction stack.
// - Exception: drain pipeline, capture program counter, then dispatch.
// - Drained means writers done, no faults possible, all cache fills finished.
// - Highest priority pending cause wins, in the fixed ten-level order.
// - Entry address takes bits 33..14 from base, 13..0 from offset.
// - Reset has top priority and enters at offset 0000.
// - Machine check 0020, arithmetic 0060, interrupt 00E0.
// - Instruction miss 03E0, instruction violation 07E0, illegal opcode 13E0.
// - Floating point disabled, bad rounding or bad datatype enters 17E0.
// - Handler call saves the address of the next sequential instruction.
// - Privileged call codes 00..3F enter at 2000 plus code shifted by 6.
// - Unprivileged call codes 80..BF enter at 3000 plus code bits 5..0 shifted by 6.
// - Call codes outside both ranges raise the illegal opcode exception.
// - Privileged call code outside kernel mode raises illegal opcode.
// - Data errors classed as bad address, miss, misalignment, other fault.
// - Data error offset chosen by class priority and handler mode.
package exd_pkg;
	localparam int PC_W     = 34;
	localparam int OFS_W    = 14;
	localparam int OPC_HI   = 31;
	localparam int OPC_LO   = 26;
	localparam logic [5:0] OPC_RETURN = 6'h1e;
	localparam logic [5:0] OPC_CALL   = 6'h00;
	localparam int CALL_HI  = 7;
	localparam int CALL_LO  = 0;
	localparam int CALL_SEL = 7;
	localparam int CALL_SH  = 6;
	localparam logic [PC_W-1:0] INSTR_STEP = 34'h4;
	localparam logic [PC_W-1:0] ALIGN_MASK = 34'h3;
	localparam logic [OFS_W-1:0] OFS_RESET  = 14'h0000;
	localparam logic [OFS_W-1:0] OFS_MCHECK = 14'h0020;
	localparam logic [OFS_W-1:0] OFS_ATRAP  = 14'h0060;
	localparam logic [OFS_W-1:0] OFS_INTR   = 14'h00e0;
	localparam logic [OFS_W-1:0] OFS_DFAULT = 14'h01e0;
	localparam logic [OFS_W-1:0] OFS_IMISS  = 14'h03e0;
	localparam logic [OFS_W-1:0] OFS_IACV   = 14'h07e0;
	localparam logic [OFS_W-1:0] OFS_DMISSN = 14'h08e0;
	localparam logic [OFS_W-1:0] OFS_DMISSP = 14'h09e0;
	localparam logic [OFS_W-1:0] OFS_UNALGN = 14'h11e0;
	localparam logic [OFS_W-1:0] OFS_ILLOPC = 14'h13e0;
	localparam logic [OFS_W-1:0] OFS_FPDIS  = 14'h17e0;
	localparam logic [OFS_W-1:0] OFS_CALLP  = 14'h2000;
	localparam logic [OFS_W-1:0] OFS_CALLU  = 14'h3000;
	localparam logic [PC_W-1:0] RESET_BASE = 34'h0;
	typedef enum logic [1:0] {EXD_RUN, EXD_DRAIN, EXD_SAVE, EXD_DISPATCH} exd_state_t;
endpackage : exd_pkg

//--- verilog/exd_prio_sel.sv
// Exception cause priority selector
`timescale 1ns/100ps
module exd_prio_sel
	import exd_pkg::*;
(
	// Pending causes
	input  wire logic             mcheck_i,
	input  wire logic             atrap_i,
	input  wire logic             intr_i,
	input  wire logic             derr_i,
	input  wire logic [OFS_W-1:0] derr_ofs_i,
	input  wire logic             imiss_i,
	input  wire logic             iacv_i,
	input  wire logic             call_i,
	input  wire logic [OFS_W-1:0] call_ofs_i,
	input  wire logic             illopc_i,
	input  wire logic             fpdis_i,
	// Result
	output logic                  any_o,
	output logic [OFS_W-1:0]      ofs_o
);
	// Fixed priority chain, all in one cycle
	always_comb begin
		any_o = 1'b1;
		if (mcheck_i) begin
			ofs_o = OFS_MCHECK;
		end else if (atrap_i) begin
			ofs_o = OFS_ATRAP;
		end else if (intr_i) begin
			ofs_o = OFS_INTR;
		end else if (derr_i) begin
			ofs_o = derr_ofs_i;
		end else if (imiss_i) begin
			ofs_o = OFS_IMISS;
		end else if (iacv_i) begin
			ofs_o = OFS_IACV;
		end else if (call_i) begin
			ofs_o = call_ofs_i;
		end else if (illopc_i) begin
			ofs_o = OFS_ILLOPC;
		end else if (fpdis_i) begin
			ofs_o = OFS_FPDIS;
		end else begin
			any_o = 1'b0;
			ofs_o = OFS_RESET;
		end
	end
endmodule : exd_prio_sel

//--- verilog/exd_top.sv
// Exception dispatch and handler return unit
`timescale 1ns/100ps
module exd_top
	import exd_pkg::*;
(
	// Clock, reset, enable
	input  wire logic             core_clk_i,
	input  wire logic             nrst_i,
	input  wire logic             clk_en_i,
	// Instruction at issue
	input  wire logic             instr_valid_i,
	input  wire logic [31:0]      instr_i,
	input  wire logic [PC_W-1:0]  instr_pc_i,
	input  wire logic             kernel_mode_i,
	// Exception causes
	input  wire logic             mcheck_i,
	input  wire logic             atrap_i,
	input  wire logic             intr_i,
	input  wire logic             imiss_i,
	input  wire logic             iacv_i,
	input  wire logic             rsvd_opc_i,
	input  wire logic             fp_op_i,
	input  wire logic             fp_enable_i,
	input  wire logic             fp_bad_round_i,
	input  wire logic             fp_bad_type_i,
	// Data-stream error classes
	input  wire logic             bad_vaddr_i,
	input  wire logic             dmiss_i,
	input  wire logic             misalign_i,
	input  wire logic             other_fault_i,
	// Pipeline drain status
	input  wire logic             regfile_writers_done_i,
	input  wire logic             no_fault_possible_i,
	input  wire logic             dcache_fills_done_i,
	// Return address and base writes from firmware
	input  wire logic             ret_addr_we_i,
	input  wire logic [PC_W-1:0]  ret_addr_wdata_i,
	input  wire logic             base_we_i,
	input  wire logic [PC_W-1:0]  base_wdata_i,
	// Outputs
	output logic                  drain_req_o,
	output logic                  redirect_o,
	output logic [PC_W-1:0]       virtual_program_counter_o,
	output logic                  privileged_handler_mode_o,
	output logic [PC_W-1:0]       exception_return_address_o,
	output logic [PC_W-1:0]       handler_base_address_o,
	output logic                  stack_push_o,
	output logic [PC_W-1:0]       stack_push_data_o,
	output logic [OFS_W-1:0]      entry_offset_o
);
	typedef struct packed {
		exd_state_t        state;
		logic              rst_pend;
		logic [OFS_W-1:0]  ofs;
		logic [PC_W-1:0]   save_pc;
		logic              drain_req;
		logic              redirect;
		logic [PC_W-1:0]   pc;
		logic              hmode;
		logic [PC_W-1:0]   ret_addr;
		logic [PC_W-1:0]   base;
		logic              push;
		logic [PC_W-1:0]   push_data;
	} exd_regs_t;

	exd_regs_t r_reg;
	exd_regs_t r_next;

	logic             is_return;
	logic             is_call;
	logic [7:0]       call_code;
	logic             call_ok;
	logic             call_illegal;
	logic [OFS_W-1:0] call_ofs;
	logic             fpdis;
	logic             derr;
	logic [OFS_W-1:0] derr_ofs;
	logic             any_cause;
	logic [OFS_W-1:0] cause_ofs;
	logic             drained;

	// Concatenate base high bits and entry offset
	function automatic logic [PC_W-1:0] entry_pc(input logic [PC_W-1:0] base,
		input logic [OFS_W-1:0] ofs);
		entry_pc = {base[PC_W-1:OFS_W], ofs};
	endfunction : entry_pc

	// Instruction decode
	always_comb begin
		is_return = instr_valid_i && (instr_i[OPC_HI:OPC_LO] == OPC_RETURN);
		is_call   = instr_valid_i && (instr_i[OPC_HI:OPC_LO] == OPC_CALL);
		call_code = instr_i[CALL_HI:CALL_LO];
		// Codes 00..3F or 80..BF are the supported ranges
		call_ok   = (call_code[6] == 1'b0) &&
			(call_code[CALL_SEL] || kernel_mode_i);
		call_illegal = is_call && !call_ok;
		call_ofs  = (call_code[CALL_SEL] ? OFS_CALLU : OFS_CALLP) |
			(OFS_W'(call_code[5:0]) << CALL_SH);
		fpdis     = fp_op_i && (!fp_enable_i || fp_bad_round_i || fp_bad_type_i);
		drained   = regfile_writers_done_i && no_fault_possible_i &&
			dcache_fills_done_i;
	end

	// Data-stream class resolution
	exd_dstream_class u_dclass (
		.bad_vaddr_i    (bad_vaddr_i),
		.dmiss_i        (dmiss_i),
		.misalign_i     (misalign_i),
		.other_fault_i  (other_fault_i),
		.handler_mode_i (r_reg.hmode),
		.derr_o         (derr),
		.derr_ofs_o     (derr_ofs)
	);

	// Cause priority resolution
	exd_prio_sel u_prio (
		.mcheck_i   (mcheck_i),
		.atrap_i    (atrap_i),
		.intr_i     (intr_i),
		.derr_i     (derr),
		.derr_ofs_i (derr_ofs),
		.imiss_i    (imiss_i),
		.iacv_i     (iacv_i),
		.call_i     (is_call && call_ok),
		.call_ofs_i (call_ofs),
		.illopc_i   (rsvd_opc_i || call_illegal),
		.fpdis_i    (fpdis),
		.any_o      (any_cause),
		.ofs_o      (cause_ofs)
	);

	// Next-state logic
	always_comb begin
		r_next = r_reg;
		r_next.redirect = 1'b0;
		r_next.push = 1'b0;
		if (ret_addr_we_i) begin
			r_next.ret_addr = ret_addr_wdata_i;
		end
		if (base_we_i) begin
			r_next.base = base_wdata_i;
		end
		case (r_reg.state)
			EXD_RUN: begin
				if (r_reg.rst_pend) begin
					// Reset entry after release
					r_next.rst_pend = 1'b0;
					r_next.redirect = 1'b1;
					r_next.hmode = 1'b1;
					r_next.ofs = OFS_RESET;
					r_next.pc = entry_pc(r_reg.base, OFS_RESET);
				end else if (any_cause) begin
					r_next.ofs = cause_ofs;
					r_next.save_pc = (is_call && call_ok && !(mcheck_i || atrap_i ||
						intr_i || derr || imiss_i || iacv_i)) ?
						instr_pc_i + INSTR_STEP : instr_pc_i;
					r_next.drain_req = 1'b1;
					r_next.state = EXD_DRAIN;
				end else if (is_return) begin
					r_next.redirect = 1'b1;
					r_next.pc = r_reg.ret_addr & ~ALIGN_MASK;
					r_next.hmode = r_reg.ret_addr[0];
					r_next.push = 1'b1;
					r_next.push_data = r_reg.ret_addr;
				end
			end
			EXD_DRAIN: begin
				if (drained) begin
					r_next.drain_req = 1'b0;
					r_next.state = EXD_SAVE;
				end
			end
			EXD_SAVE: begin
				r_next.ret_addr = r_reg.save_pc;
				r_next.state = EXD_DISPATCH;
			end
			EXD_DISPATCH: begin
				r_next.redirect = 1'b1;
				r_next.hmode = 1'b1;
				r_next.pc = entry_pc(r_reg.base, r_reg.ofs);
				r_next.state = EXD_RUN;
			end
			default: begin
				r_next.state = EXD_RUN;
			end
		endcase
	end

	// State register; reset itself schedules the reset entry
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			r_reg <= '0;
			r_reg.state <= EXD_RUN;
			r_reg.rst_pend <= 1'b1;
			r_reg.hmode <= 1'b1;
			r_reg.base <= RESET_BASE;
		end else if (clk_en_i) begin
			r_reg <= r_next;
		end
	end

	// Outputs straight from flip-flops
	assign drain_req_o = r_reg.drain_req;
	assign redirect_o = r_reg.redirect;
	assign virtual_program_counter_o = r_reg.pc;
	assign privileged_handler_mode_o = r_reg.hmode;
	assign exception_return_address_o = r_reg.ret_addr;
	assign handler_base_address_o = r_reg.base;
	assign stack_push_o = r_reg.push;
	assign stack_push_data_o = r_reg.push_data;
	assign entry_offset_o = r_reg.ofs;
endmodule : exd_top
